/* pkg/pfr_defs.svh */
// Constants for the pin function and reset block.
// Assumes a 200 MHz oscillator clock; included by bare name.
`ifndef PFR_DEFS_SVH
`define PFR_DEFS_SVH
`define PFR_RST_QUAL_PERIODS 64
`define PFR_INT_CODE_TOP 18'h03fff
`define PFR_MAP_HI_BIT 1
`define PFR_MAP_LO_BIT 0
`define PFR_PORT_RESET 8'hff
`endif

/* pkg/pfr_pkg.sv */
// Types for the pin function and reset block.
// Assumes nothing beyond a SystemVerilog compiler.
package pfr_pkg;
  typedef enum logic [1:0] {PFR_RUN, PFR_IDLE, PFR_PDOWN, PFR_RESET} pfr_state_t;
  typedef struct packed {
    logic req;
    logic code;
    logic wr;
    logic [17:0] addr;
    logic [7:0] wdata;
  } pfr_bus_req_t;
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe_n;
  } pfr_port_t;
endpackage : pfr_pkg

/* rtl/pfr_irq_sense.sv */
// One external interrupt input with edge or level sensing.
// Assumes the pin is synchronous to clock.
module pfr_irq_sense (
  input wire logic clock,
  input wire logic reset,
  input wire logic pin_n,
  input wire logic edge_sel,
  input wire logic flag_clear,
  output logic flag_reg
);
  logic pin_last_reg;
  logic hit;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_last_reg <= 1'b1;
    end else begin
      pin_last_reg <= pin_n;
    end
  end

  // R4 R5 edge or level
  assign hit = edge_sel ? (pin_last_reg && !pin_n) : !pin_n;

  // Set wins over clear so an event in the clearing cycle is kept.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flag_reg <= 1'b0;
    end else if (hit) begin
      flag_reg <= 1'b1;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  property p_edge_set;
    @(posedge clock) disable iff (reset) (edge_sel && $past(pin_n) && !pin_n) |=> flag_reg;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge did not set flag"); // R4
  property p_level_set;
    @(posedge clock) disable iff (reset) (!edge_sel && !pin_n) |=> flag_reg;
  endproperty
  a_level_set: assert property (p_level_set) else $error("low level did not set flag"); // R5
  property p_flag_hold;
    @(posedge clock) disable iff (reset) (flag_reg && !flag_clear) |=> flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear"); // R4 R5
endmodule : pfr_irq_sense

/* rtl/pfr_pin_function.sv */
// Pin function, bus steering and reset qualification of the controller.
// Assumes all pins synchronous to clock; core issues bus requests.
// Behaviour
// R1: Sampled select low sends every code fetch to the external bus.
// R2: Select high fetches internal inside internal range, external otherwise.
// R3: Select is captured during reset; the captured value steers code.
// R4: With edge select set, a falling interrupt pin sets its flag.
// R5: With edge select clear, a low interrupt pin sets its flag.
// R6: Reset pin high for 64 periods enters internal reset; code resets at once on reset high.
// R7: Reset pin high forces port pins to reset state asynchronously.
// R8: Reset pin during idle or powerdown returns to normal operation.
// R9: Code read strobe only for the range chosen by mapping bits.
// R10: Mapping bits choose data read strobe or address bit sixteen.
// R11: Page mode: low address on port zero, high address and data on port two.
// R12: Port zero as general I/O only pulls low, floats for one.
// R13: Counter-array pins are inputs in capture, outputs in compare or PWM.
// R14: External clock input can step the counter array timer.
// R15: Receive pin bidirectional in serial mode 0, input otherwise.
// R16: Nonpage mode multiplexes low address and data on port zero.
// R17: Address latch strobe pulses at bus cycle start with valid address.
// R18: In serial mode 0 the transmit pin carries the shift clock.
// R19: With no alternate function a pin is its general port bit.
`include "pfr_defs.svh"
module pfr_pin_function #(
  parameter int RST_CYCLES = `PFR_RST_QUAL_PERIODS,
  parameter logic [17:0] INT_CODE_TOP = `PFR_INT_CODE_TOP
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic ext_access_select,
  input wire logic sleep_idle,
  input wire logic sleep_pdown,
  input wire logic [1:0] user_config_byte0,
  input wire logic page_mode,
  input wire pfr_pkg::pfr_bus_req_t bus_req,
  input wire logic [7:0] p0_gpio,
  input wire logic [7:0] p2_gpio,
  input wire logic [1:0] ext_irq_pins,
  input wire logic [1:0] irq_edge_select,
  input wire logic [1:0] irq_flag_clear,
  input wire logic [4:0] ca_capture_mode,
  input wire logic [4:0] ca_out,
  input wire logic [4:0] counter_array_pins_in,
  input wire logic counter_ext_clock,
  input wire logic [1:0] serial_mode,
  input wire logic ser_rx_drive,
  input wire logic ser_rx_out,
  input wire logic ser_tx_data,
  input wire logic ser_shift_clk,
  input wire logic rx_pin_in,
  output pfr_pkg::pfr_port_t port0_reg,
  output pfr_pkg::pfr_port_t port2_reg,
  output logic code_read_strobe_n_reg,
  output logic shared_rd_pin_reg,
  output logic addr_latch_strobe_reg,
  output logic int_fetch_reg,
  output logic core_reset_reg,
  output pfr_pkg::pfr_state_t state_reg,
  output logic [1:0] ext_irq_flags,
  output logic [4:0] counter_array_pins_o_reg,
  output logic [4:0] counter_array_pins_oe_n_reg,
  output logic [4:0] ca_capture_seen_reg,
  output logic ca_ext_tick_reg,
  output logic rx_o_reg,
  output logic rx_oe_n_reg,
  output logic rx_data_reg,
  output logic tx_o_reg
);
  logic strap_latched_reg;
  logic [6:0] rst_cnt_reg;
  logic [1:0] phase_reg;
  logic ext_clk_last_reg;
  logic ext_fetch;
  logic data_rd;
  logic code_in_map;
  logic bus_take;

  default clocking cb_pfr @(posedge clock); endclocking
  default disable iff (reset);

  // R3 capture strap
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      strap_latched_reg <= 1'b0;
    end else if (core_reset_reg) begin
      strap_latched_reg <= ext_access_select;
    end
  end

  // R1 R2 code steering
  assign ext_fetch = !strap_latched_reg || (bus_req.addr > INT_CODE_TOP);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      int_fetch_reg <= 1'b0;
    end else begin
      int_fetch_reg <= bus_req.req && bus_req.code && !ext_fetch && !core_reset_reg;
    end
  end

  // R6 qualify reset
  // R8 wake on reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rst_cnt_reg <= 7'h00;
      core_reset_reg <= 1'b1;
      state_reg <= pfr_pkg::PFR_RESET;
    end else begin
      if (rst_cnt_reg != 7'h00) begin
        rst_cnt_reg <= rst_cnt_reg - 7'h01;
      end
      case (state_reg)
        pfr_pkg::PFR_RESET: begin
          if (rst_cnt_reg == 7'h00 && core_reset_reg) begin
            rst_cnt_reg <= 7'(RST_CYCLES - 1);
            core_reset_reg <= 1'b0;
          end else if (rst_cnt_reg == 7'h01) begin
            state_reg <= pfr_pkg::PFR_RUN;
          end
        end
        pfr_pkg::PFR_RUN: begin
          if (sleep_pdown) begin
            state_reg <= pfr_pkg::PFR_PDOWN;
          end else if (sleep_idle) begin
            state_reg <= pfr_pkg::PFR_IDLE;
          end
        end
        pfr_pkg::PFR_IDLE, pfr_pkg::PFR_PDOWN: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= pfr_pkg::PFR_RESET;
        end
      endcase
    end
  end

  // R9 R10 strobe mapping: map 11 limits code to the low 64K, hi bit gives the address pin.
  assign code_in_map = (user_config_byte0 == 2'b11) ? (bus_req.addr[17:16] == 2'b00) : 1'b1;
  assign data_rd = bus_req.req && !bus_req.code && !bus_req.wr;
  assign bus_take = bus_req.req && (!bus_req.code || ext_fetch) && !core_reset_reg;

  // R17 latch strobe phase
  // R7 async port reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_reg <= 2'b00;
      addr_latch_strobe_reg <= 1'b0;
      code_read_strobe_n_reg <= 1'b1;
      shared_rd_pin_reg <= 1'b1;
      port0_reg <= '{o: `PFR_PORT_RESET, oe_n: 8'hff};
      port2_reg <= '{o: `PFR_PORT_RESET, oe_n: 8'hff};
    end else if (bus_req.req && (!bus_req.code || ext_fetch) && !core_reset_reg) begin
      phase_reg <= (phase_reg == 2'b10) ? 2'b00 : phase_reg + 2'b01;
      addr_latch_strobe_reg <= (phase_reg == 2'b00);
      // R9 code strobe range
      code_read_strobe_n_reg <= !(bus_req.code && code_in_map && phase_reg != 2'b00);
      // R10 shared pin
      if (user_config_byte0[`PFR_MAP_HI_BIT]) begin
        shared_rd_pin_reg <= bus_req.addr[16];
      end else begin
        shared_rd_pin_reg <= !(data_rd && phase_reg != 2'b00);
      end
      if (page_mode) begin
        // R11 page mode ports
        port0_reg <= '{o: bus_req.addr[7:0], oe_n: 8'h00};
        port2_reg <= '{o: (phase_reg == 2'b00) ? bus_req.addr[15:8] : bus_req.wdata,
                       oe_n: (phase_reg == 2'b00 || bus_req.wr) ? 8'h00 : 8'hff};
      end else begin
        // R16 nonpage multiplex
        port0_reg <= '{o: (phase_reg == 2'b00) ? bus_req.addr[7:0] : bus_req.wdata,
                       oe_n: (phase_reg == 2'b00 || bus_req.wr) ? 8'h00 : 8'hff};
        port2_reg <= '{o: bus_req.addr[15:8], oe_n: 8'h00};
      end
    end else begin
      phase_reg <= 2'b00;
      addr_latch_strobe_reg <= 1'b0;
      code_read_strobe_n_reg <= 1'b1;
      shared_rd_pin_reg <= user_config_byte0[`PFR_MAP_HI_BIT] ? 1'b0 : 1'b1;
      // R12 open drain port zero
      // R19 general port bits
      port0_reg <= '{o: 8'h00, oe_n: p0_gpio};
      port2_reg <= '{o: p2_gpio, oe_n: 8'h00};
    end
  end

  // R4 R5 interrupt sensing
  for (genvar i = 0; i < 2; i++) begin : g_irq
    pfr_irq_sense u_sense (
      .clock(clock),
      .reset(reset),
      .pin_n(ext_irq_pins[i]),
      .edge_sel(irq_edge_select[i]),
      .flag_clear(irq_flag_clear[i]),
      .flag_reg(ext_irq_flags[i])
    );
  end

  // R13 counter array direction
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      counter_array_pins_o_reg <= 5'h1f;
      counter_array_pins_oe_n_reg <= 5'h1f;
      ca_capture_seen_reg <= 5'h00;
    end else begin
      counter_array_pins_o_reg <= ca_out;
      counter_array_pins_oe_n_reg <= ca_capture_mode;
      ca_capture_seen_reg <= counter_array_pins_in & ca_capture_mode;
    end
  end

  // R14 external clock tick
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_clk_last_reg <= 1'b0;
      ca_ext_tick_reg <= 1'b0;
    end else begin
      ext_clk_last_reg <= counter_ext_clock;
      ca_ext_tick_reg <= ext_clk_last_reg && !counter_ext_clock;
    end
  end

  // R15 R18 serial pins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_o_reg <= 1'b1;
      rx_oe_n_reg <= 1'b1;
      rx_data_reg <= 1'b1;
      tx_o_reg <= 1'b1;
    end else begin
      rx_o_reg <= ser_rx_out;
      rx_oe_n_reg <= !(serial_mode == 2'b00 && ser_rx_drive);
      rx_data_reg <= rx_pin_in;
      tx_o_reg <= (serial_mode == 2'b00) ? ser_shift_clk : ser_tx_data;
    end
  end

  property p_ea_low; !strap_latched_reg |=> !int_fetch_reg; endproperty
  a_ea_low: assert property (p_ea_low) else $error("internal fetch with select low"); // R1
  property p_int_fetch;
    strap_latched_reg && bus_req.req && bus_req.code && !core_reset_reg &&
      bus_req.addr <= INT_CODE_TOP |=> int_fetch_reg;
  endproperty
  a_int_fetch: assert property (p_int_fetch) else $error("internal fetch missing"); // R2
  property p_ext_range; bus_req.addr > INT_CODE_TOP |=> !int_fetch_reg; endproperty
  a_ext_range: assert property (p_ext_range) else $error("fetch above range kept inside"); // R2
  property p_ea_hold;
    !core_reset_reg && !$past(core_reset_reg) |-> $stable(strap_latched_reg);
  endproperty
  a_ea_hold: assert property (p_ea_hold) else $error("select changed after reset"); // R3
  property p_ale_start; addr_latch_strobe_reg |=> !addr_latch_strobe_reg; endproperty
  a_ale_start: assert property (p_ale_start) else $error("latch strobe too long"); // R17
  property p_tx_mode0; serial_mode == 2'b00 |=> tx_o_reg == $past(ser_shift_clk); endproperty
  a_tx_mode0: assert property (p_tx_mode0) else $error("shift clock missing"); // R18
  property p_rx_in; serial_mode != 2'b00 |=> rx_oe_n_reg; endproperty
  a_rx_in: assert property (p_rx_in) else $error("receive pin driven"); // R15
  property p_ca_dir; 1'b1 |=> counter_array_pins_oe_n_reg == $past(ca_capture_mode); endproperty
  a_ca_dir: assert property (p_ca_dir) else $error("counter pin direction wrong"); // R13
  property p_wake;
    state_reg == pfr_pkg::PFR_RESET && !core_reset_reg && rst_cnt_reg == 7'h01
      |=> state_reg == pfr_pkg::PFR_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("no return to run after reset"); // R8
  property p_p0_od; !bus_req.req |=> port0_reg.o == 8'h00; endproperty
  a_p0_od: assert property (p_p0_od) else $error("port zero drove high"); // R12
  property p_code_map;
    user_config_byte0 == 2'b11 && bus_req.addr[17:16] != 2'b00 |=> code_read_strobe_n_reg;
  endproperty
  a_code_map: assert property (p_code_map) else $error("code strobe outside map"); // R9
  property p_shared_addr;
    bus_take && user_config_byte0[`PFR_MAP_HI_BIT]
      |=> shared_rd_pin_reg == $past(bus_req.addr[16]);
  endproperty
  a_shared_addr: assert property (p_shared_addr) else $error("shared pin not address"); // R10
  property p_page_low; bus_take && page_mode |=> port0_reg.o == $past(bus_req.addr[7:0]); endproperty
  a_page_low: assert property (p_page_low) else $error("page mode low address lost"); // R11
  property p_nonpage_addr;
    bus_take && !page_mode && phase_reg == 2'b00 |=> port0_reg.o == $past(bus_req.addr[7:0]);
  endproperty
  a_nonpage_addr: assert property (p_nonpage_addr) else $error("nonpage address missing"); // R16
  property p_gpio_p2; !bus_req.req |=> port2_reg.o == $past(p2_gpio); endproperty
  a_gpio_p2: assert property (p_gpio_p2) else $error("port two not general bit"); // R19
  property p_ext_tick;
    $fell(counter_ext_clock) && !$past(core_reset_reg) |=> ca_ext_tick_reg;
  endproperty
  a_ext_tick: assert property (p_ext_tick) else $error("external clock tick missing"); // R14
  c_ext: cover property (@(posedge clock) addr_latch_strobe_reg);
  c_int: cover property (@(posedge clock) int_fetch_reg);
  c_irq: cover property (@(posedge clock) ext_irq_flags[0]);
endmodule : pfr_pin_function

/* testbench/pfr_ext_mem.sv */
// External memory side: an address latch on the multiplexed port pins.
// Assumes the pin block drives the ports and the latch strobe from clock.
module pfr_ext_mem (
  input wire logic clock,
  input wire logic latch_strobe,
  input wire pfr_pkg::pfr_port_t port0,
  input wire pfr_pkg::pfr_port_t port2,
  output logic [15:0] latched_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] p0_wire;
  logic [7:0] p2_wire;
  // Released lines read high through the board pull-ups.
  assign p0_wire = port0.o | port0.oe_n;
  assign p2_wire = port2.o | port2.oe_n;
  always_ff @(posedge clock) begin
    if (latch_strobe) begin
      latched_addr <= {p2_wire, p0_wire};
    end
  end
endmodule : pfr_ext_mem

/* testbench/tb_pfr_pin_function.sv */
// Self-checking bench for the pin block, with an external address latch model.
// Assumes a 200 MHz clock and a reset stretch shortened to four cycles.
`include "pfr_defs.svh"
module tb_pfr_pin_function;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, ext_access_select, sleep_idle, sleep_pdown, page_mode, strap;
  logic counter_ext_clock, ser_rx_drive, ser_rx_out, ser_tx_data, ser_shift_clk, rx_pin_in;
  logic [1:0] user_config_byte0, ext_irq_pins, irq_edge_select, irq_flag_clear, serial_mode;
  logic [7:0] p0_gpio, p2_gpio;
  logic [4:0] ca_capture_mode, ca_out, counter_array_pins_in;
  pfr_pkg::pfr_bus_req_t bus_req;
  pfr_pkg::pfr_port_t port0_reg, port2_reg;
  pfr_pkg::pfr_state_t state_reg;
  logic code_read_strobe_n_reg, shared_rd_pin_reg, addr_latch_strobe_reg, int_fetch_reg;
  logic rx_o_reg, rx_oe_n_reg, rx_data_reg, tx_o_reg, ca_ext_tick_reg, core_reset_reg;
  logic [1:0] ext_irq_flags;
  logic [4:0] counter_array_pins_o_reg, counter_array_pins_oe_n_reg, ca_capture_seen_reg;
  logic [15:0] latched;
  logic [15:0] exp_q[$];
  int n_errors, tests_run, seed, cycles, ticks;
  pfr_pin_function #(.RST_CYCLES(4)) pfr_pin_function_i (.clock, .reset, .ext_access_select,
    .sleep_idle, .sleep_pdown, .user_config_byte0, .page_mode, .bus_req, .p0_gpio, .p2_gpio,
    .ext_irq_pins, .irq_edge_select, .irq_flag_clear, .ca_capture_mode, .ca_out,
    .counter_array_pins_in, .counter_ext_clock, .serial_mode, .ser_rx_drive, .ser_rx_out,
    .ser_tx_data, .ser_shift_clk, .rx_pin_in, .port0_reg, .port2_reg, .code_read_strobe_n_reg,
    .shared_rd_pin_reg, .addr_latch_strobe_reg, .int_fetch_reg, .core_reset_reg, .state_reg,
    .ext_irq_flags, .counter_array_pins_o_reg, .counter_array_pins_oe_n_reg,
    .ca_capture_seen_reg, .ca_ext_tick_reg, .rx_o_reg, .rx_oe_n_reg, .rx_data_reg, .tx_o_reg);
  pfr_ext_mem pfr_ext_mem_i (.clock, .latch_strobe(addr_latch_strobe_reg), .port0(port0_reg),
    .port2(port2_reg), .latched_addr(latched));
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  // The whole run needs well under a thousand cycles.
  // Counting at the falling edge keeps the tick count clear of the launching edge.
  always @(negedge clock) begin
    cycles++;
    ticks += (ca_ext_tick_reg === 1'b1);
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic do_reset(input logic s);
    reset = 1;
    ext_access_select = s;
    strap = s;
    #1;
    chk("reset pins", {port0_reg, port2_reg, code_read_strobe_n_reg}, 33'h1ffffffff);
    cyc(5);
    reset = 0;
    cyc(1);
    ext_access_select = ~s;
    chk("stretch", state_reg == pfr_pkg::PFR_RUN, 0);
    cyc(5);
    chk("running", state_reg, pfr_pkg::PFR_RUN);
  endtask : do_reset
  task automatic bus(input logic code, input logic wr, input logic [17:0] a, input logic [7:0] d);
    logic ale, intf, strb, ext, shared;
    logic [7:0] dat;
    ale = 0;
    intf = 0;
    ext = !code || !strap || a > `PFR_INT_CODE_TOP;
    bus_req = {1'b1, code, wr, a, d};
    for (int i = 0; i < 3 && !ale; i++) begin
      @(negedge clock);
      intf |= int_fetch_reg;
      ale = addr_latch_strobe_reg;
    end
    if (ale) begin
      exp_q.push_back(a[15:0]);
      @(negedge clock);
      strb = ~code_read_strobe_n_reg;
      shared = shared_rd_pin_reg;
      dat = page_mode ? port2_reg.o : port0_reg.o;
      @(negedge clock);
      chk("latched addr", latched, exp_q.pop_front());
      chk("code strobe", strb, code && !(user_config_byte0 == 2'b11 && a > 18'h0ffff));
      chk("shared pin", shared, user_config_byte0[1] ? a[16] : code || wr);
      if (wr) chk("write data", dat, d);
    end
    bus_req.req = 0;
    chk("steering", {ale, intf}, {ext, !ext});
    @(negedge clock);
  endtask : bus
  initial begin
    logic [17:0] a;
    {seed, n_errors, tests_run, cycles} = {32'd87, 96'd0};
    {sleep_idle, sleep_pdown, page_mode, counter_ext_clock, ser_rx_drive, ser_rx_out} = '0;
    {ser_tx_data, ser_shift_clk, rx_pin_in, user_config_byte0, irq_edge_select} = '0;
    {irq_flag_clear, serial_mode, p0_gpio, p2_gpio, bus_req} = '0;
    {ca_capture_mode, ca_out, counter_array_pins_in, ext_irq_pins} = 17'h00003;
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0]);
      for (int k = 0; k < 8; k++) begin
        {user_config_byte0, page_mode} = {k[2:1], k[1]};
        a = $random(seed);
        if (k < 2) a = a & 18'h03fff;
        bus(k[0], ~k[0] & k[2], a, $random(seed));
      end
      $display("Test bus steering with strap %0d done", s);
    end
    repeat (6) begin
      {p0_gpio, p2_gpio, ca_capture_mode, ca_out, serial_mode, ser_rx_drive} = $random(seed);
      {ser_tx_data, ser_shift_clk, counter_array_pins_in, rx_pin_in, ser_rx_out} = $random(seed);
      cyc(3);
      chk("p0 enables", port0_reg.oe_n, p0_gpio); // Open drain.
      chk("p2 out", port2_reg.o, p2_gpio); // Plain port.
      chk("ca enables", counter_array_pins_oe_n_reg, ca_capture_mode);
      chk("ca out", counter_array_pins_o_reg | ca_capture_mode, ca_out | ca_capture_mode);
      chk("tx pin", tx_o_reg, serial_mode == 0 ? ser_shift_clk : ser_tx_data);
      chk("rx enable", rx_oe_n_reg, serial_mode == 0 ? !ser_rx_drive : 1'b1);
    end
    $display("Test pin directions done");
    ticks = 0;
    repeat (6) begin
      counter_ext_clock = 1;
      cyc(2);
      counter_ext_clock = 0;
      cyc(2);
    end
    cyc(4);
    chk("ext clock ticks", ticks, 6);
    for (int e = 1; e < 3; e++) begin
      irq_edge_select = e[1:0];
      ext_irq_pins = 2'b00;
      cyc(3);
      irq_flag_clear = 2'b11;
      cyc(1);
      irq_flag_clear = 0;
      cyc(3);
      chk("irq held low", ext_irq_flags, {~e[1:0]});
      ext_irq_pins = 2'b11;
      cyc(2);
      ext_irq_pins = 2'b00;
      cyc(3);
      chk("irq after fall", ext_irq_flags, 2'b11);
    end
    $display("Test interrupt sensing done");
    for (int m = 0; m < 2; m++) begin
      {sleep_idle, sleep_pdown} = m[0] ? 2'b01 : 2'b10;
      cyc(3);
      {sleep_idle, sleep_pdown} = 2'b00;
      cyc(2);
      chk("sleeping", state_reg, m[0] ? pfr_pkg::PFR_PDOWN : pfr_pkg::PFR_IDLE);
      do_reset(1);
    end
    $display("Test wake by reset done");
    close_out();
  end
endmodule : tb_pfr_pin_function
